// ===== spc_params.svh
// Constants of the sleep pin control and power register block.
// Assumes inclusion by bare name; definitions only.
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave
`define SPC_OFS_CONTROL 6'h00
`define SPC_OFS_STATUS 6'h04
`define SPC_OFS_SCRATCH 6'h08
`define SPC_OFS_WAKE 6'h0C
`define SPC_OFS_CONFIG 6'h10
`define SPC_OFS_CLOCK 6'h14
`define SPC_OFS_GPIO_SLEEP 6'h18
`define SPC_OFS_OSC 6'h1C
`define SPC_OFS_PERIPH_MODE 6'h20

// Field positions
`define SPC_CTL_SF 0
`define SPC_ST_SS 0
`define SPC_ST_BFS 1
`define SPC_ST_VFS 2
`define SPC_ST_DH 3
`define SPC_ST_PH 4
`define SPC_CFG_FAST_OSC_POWERDOWN_ENABLE 0
`define SPC_CFG_FP 1
`define SPC_CFG_FS 2
`define SPC_CFG_FO 3
`define SPC_OSC_READY 0
`define SPC_PM_ZERO 0

// Implemented-bit masks and reset values
`define SPC_MASK_STATUS 32'h0000001F
`define SPC_MASK_WAKE 32'h8FFFFFFF
`define SPC_MASK_CONFIG 32'h0000000F
`define SPC_MASK_CLOCK 32'h0000001F
`define SPC_MASK_GPIO 32'h0FFFFFFF
`define SPC_RST_WAKE 32'h00000003
`define SPC_RST_ZERO 32'h00000000

// Timing: slow oscillator settle time and clock rate
`define SPC_OSC_SETTLE_MS 2000
`define SPC_CLK_KHZ 100000

`endif

// ===== spc_pkg.sv
// Types of the sleep pin control and power register block.
// Assumes nothing beyond a SystemVerilog compiler.
package spc_pkg;
    // Power mode of the sequencer
    typedef enum logic [0:0] {
        SPC_MODE_RUN = 1'b0,
        SPC_MODE_SLEEP = 1'b1
    } spc_mode_t;
endpackage : spc_pkg

// ===== spc_power_regs.sv
// Sleep pin control and power manager registers, Avalon-MM slave.
// Assumes the slow always-on clock at i_sys_clk, hard reset on i_srst,
// and wake sources and fault pins already synchronous to that clock.
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "spc_params.svh"

// Function
// - Memory-class outputs low in sleep, held afterwards
// - Static and card strobes high, or floated
// - GPIO outputs held, inputs still sampled
// - Peripheral pins input, zero or float, held
// - Fifth class driven, sixth class floated
// - Seventh class sampled, eighth class ignored
// - Nine 32-bit power registers on the bus
// - Sleep entry loads GPIO sleep values
// - Oscillator status bit shows slow oscillator ready
// - Writing one to control bit 0 sleeps
// - Sleep force self-clears on exit, reset
// - Control reserved bits read zero
// - Config bit 0 stops fast oscillator in sleep
// - Config bit 1 floats card strobes
// - Socket select and attribute follow address
// - Config bit 2 floats static strobes
// - Config bit 3 skips oscillator settle wait
// - Memory hold set on exit, write-one clears
// - Peripheral hold set on exit, write-one clears
module spc_power_regs #(
    parameter int unsigned OSC_SETTLE_CYCLES = `SPC_OSC_SETTLE_MS * `SPC_CLK_KHZ
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Avalon-MM slave
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Sleep causes and wake sources
    input wire logic i_vdd_fault,
    input wire logic i_batt_fault,
    input wire logic [31:0] i_wake_sources,
    // Power mode and oscillators
    output logic o_sleeping,
    output logic o_fast_osc_stop,
    output logic o_slow_osc_ready,
    output logic [4:0] o_clock_config,
    // Memory class: address, data, row and column strobes, socket select, attribute
    output logic o_mem_class_hold_low,
    output logic o_card_addr_hold_low,
    // Static selects, output and write enable
    output logic o_static_sleep_drive_high,
    output logic o_static_ctl_oe,
    // Card control strobes
    output logic o_card_sleep_drive_high,
    output logic o_card_ctl_oe,
    // General-purpose pins
    input wire logic [27:0] i_gpio_dir_out,
    input wire logic [27:0] i_gpio_out,
    input wire logic [27:0] i_gpio_in,
    output logic [27:0] o_gpio_out,
    output logic [27:0] o_gpio_oe,
    output logic [27:0] o_gpio_in_sampled,
    // Peripheral class pins
    output logic o_periph_hold,
    output logic o_periph_drive_zero,
    output logic o_periph_float,
    output logic o_periph_rx_enable,
    // Fifth to eighth class pins
    output logic o_class5_oe,
    output logic o_class6_oe,
    output logic o_class7_rx_enable,
    output logic o_class8_rx_enable,
    input wire logic i_class8_in,
    output logic o_class8_in_sampled
);

    // Byte-enable expansion to a bit mask
    function automatic logic [31:0] spc_be_mask(input logic [3:0] be);
        spc_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : spc_be_mask

    // Address match for one register
    function automatic logic spc_hit(input logic [5:0] addr, input logic [5:0] ofs);
        spc_hit = (addr == ofs);
    endfunction : spc_hit

    // Register state
    spc_pkg::spc_mode_t mode_q, mode_d;
    logic ack_q;
    logic [31:0] rdata_q;
    logic sf_q;
    logic [31:0] status_q;
    logic [31:0] scratch_q;
    logic [31:0] wake_q;
    logic [31:0] config_q;
    logic [31:0] clock_q;
    logic [31:0] gpio_sleep_q;
    logic [31:0] pmode_q;
    logic osc_ready_q;
    logic [31:0] osc_cnt_q;
    logic [27:0] gpio_out_q;
    logic [27:0] gpio_oe_q;
    logic [27:0] gpio_in_q;
    logic class8_q;

    // Bus handshake: one wait cycle, then the access completes
    wire req = i_avs_read | i_avs_write;
    wire rd_take = i_avs_read & ~ack_q;
    wire wr_fire = i_avs_write & ack_q;
    wire [31:0] wmask = spc_be_mask(i_avs_byteenable);
    wire [31:0] wbits = i_avs_writedata & wmask;
    assign o_avs_waitrequest = req & ~ack_q;
    assign o_avs_readdata = rdata_q;

    // Write strobes per register
    wire wr_ctl = wr_fire & spc_hit(i_avs_address, `SPC_OFS_CONTROL);
    wire wr_st = wr_fire & spc_hit(i_avs_address, `SPC_OFS_STATUS);
    wire wr_scr = wr_fire & spc_hit(i_avs_address, `SPC_OFS_SCRATCH);
    wire wr_wake = wr_fire & spc_hit(i_avs_address, `SPC_OFS_WAKE);
    wire wr_cfg = wr_fire & spc_hit(i_avs_address, `SPC_OFS_CONFIG);
    wire wr_clk = wr_fire & spc_hit(i_avs_address, `SPC_OFS_CLOCK);
    wire wr_gpio = wr_fire & spc_hit(i_avs_address, `SPC_OFS_GPIO_SLEEP);
    wire wr_pm = wr_fire & spc_hit(i_avs_address, `SPC_OFS_PERIPH_MODE);

    // Read multiplexer; unmapped addresses and reserved bits read zero
    wire [31:0] rd_mux =
        spc_hit(i_avs_address, `SPC_OFS_CONTROL) ? {31'h0000_0000, sf_q} :
        spc_hit(i_avs_address, `SPC_OFS_STATUS) ? status_q :
        spc_hit(i_avs_address, `SPC_OFS_SCRATCH) ? scratch_q :
        spc_hit(i_avs_address, `SPC_OFS_WAKE) ? wake_q :
        spc_hit(i_avs_address, `SPC_OFS_CONFIG) ? config_q :
        spc_hit(i_avs_address, `SPC_OFS_CLOCK) ? clock_q :
        spc_hit(i_avs_address, `SPC_OFS_GPIO_SLEEP) ? gpio_sleep_q :
        spc_hit(i_avs_address, `SPC_OFS_OSC) ? {31'h0000_0000, osc_ready_q} :
        spc_hit(i_avs_address, `SPC_OFS_PERIPH_MODE) ? pmode_q :
        32'h0000_0000;

    // Merge of a read-write register with masked write data
    function automatic logic [31:0] spc_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [31:0] wm, input logic [31:0] impl);
        spc_merge = ((old & ~wm) | (wd & wm)) & impl;
    endfunction : spc_merge

    // Mode sequencing: entry by force bit or fault, exit by an enabled wake source
    wire in_sleep = (mode_q == spc_pkg::SPC_MODE_SLEEP);
    wire fault = i_vdd_fault | i_batt_fault;
    wire sleep_entry = ~in_sleep & (sf_q | fault);
    wire wake_exit = in_sleep & ~fault & (|(i_wake_sources & wake_q));

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            spc_pkg::SPC_MODE_RUN: begin
                if (sleep_entry) begin
                    mode_d = spc_pkg::SPC_MODE_SLEEP;
                end
            end
            spc_pkg::SPC_MODE_SLEEP: begin
                if (wake_exit) begin
                    mode_d = spc_pkg::SPC_MODE_RUN;
                end
            end
            default: begin
                mode_d = spc_pkg::SPC_MODE_RUN;
            end
        endcase
    end

    // Status flags: hardware sets win over a write-one clear in the same cycle
    wire [31:0] st_set = ({31'h0000_0000, sleep_entry & sf_q} << `SPC_ST_SS)
                       | ({31'h0000_0000, i_batt_fault} << `SPC_ST_BFS)
                       | ({31'h0000_0000, sleep_entry & i_vdd_fault & ~sf_q} << `SPC_ST_VFS)
                       | ({31'h0000_0000, wake_exit} << `SPC_ST_DH)
                       | ({31'h0000_0000, wake_exit} << `SPC_ST_PH);
    wire [31:0] st_clr = wr_st ? wbits : 32'h0000_0000;
    wire [31:0] st_d = ((status_q & ~st_clr) | st_set) & `SPC_MASK_STATUS;

    // Sleep force: write one sets, zero is ignored, exit clears
    wire sf_d = (sf_q & ~wake_exit) | (wr_ctl & wbits[`SPC_CTL_SF]);

    // Slow oscillator settle counter, bypassed by the force-ready bit
    wire cnt_done = (osc_cnt_q >= (OSC_SETTLE_CYCLES - 1));
    wire osc_ready_d = osc_ready_q | cnt_done | config_q[`SPC_CFG_FO];

    // Bus and mode registers
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            mode_q <= spc_pkg::SPC_MODE_RUN;
            sf_q <= 1'b0;
            status_q <= `SPC_RST_ZERO;
        end else begin
            ack_q <= req & ~ack_q;
            rdata_q <= rd_take ? rd_mux : rdata_q;
            mode_q <= mode_d;
            sf_q <= sf_d;
            status_q <= st_d;
        end
    end

    // Software-owned registers; a long settle cannot be sped up except by the bypass
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            scratch_q <= `SPC_RST_ZERO;
            wake_q <= `SPC_RST_WAKE;
            config_q <= `SPC_RST_ZERO;
            clock_q <= `SPC_RST_ZERO;
            gpio_sleep_q <= `SPC_RST_ZERO;
            pmode_q <= `SPC_RST_ZERO;
            osc_ready_q <= 1'b0;
            osc_cnt_q <= 32'h0000_0000;
        end else begin
            scratch_q <= wr_scr ? spc_merge(scratch_q, i_avs_writedata, wmask, 32'hFFFF_FFFF)
                                : scratch_q;
            wake_q <= wr_wake ? spc_merge(wake_q, i_avs_writedata, wmask, `SPC_MASK_WAKE)
                              : wake_q;
            config_q <= wr_cfg ? spc_merge(config_q, i_avs_writedata, wmask, `SPC_MASK_CONFIG)
                               : config_q;
            clock_q <= wr_clk ? spc_merge(clock_q, i_avs_writedata, wmask, `SPC_MASK_CLOCK)
                              : clock_q;
            gpio_sleep_q <= wr_gpio ? spc_merge(gpio_sleep_q, i_avs_writedata, wmask,
                                                `SPC_MASK_GPIO) : gpio_sleep_q;
            pmode_q <= wr_pm ? spc_merge(pmode_q, i_avs_writedata, wmask, 32'h0000_0001)
                             : pmode_q;
            osc_ready_q <= osc_ready_d;
            osc_cnt_q <= cnt_done ? osc_cnt_q : osc_cnt_q + 32'h0000_0001;
        end
    end

    // GPIO pins: sleep values loaded at entry and held, inputs always sampled
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            gpio_out_q <= 28'h000_0000;
            gpio_oe_q <= 28'h000_0000;
            gpio_in_q <= 28'h000_0000;
            class8_q <= 1'b0;
        end else begin
            if (sleep_entry) begin
                gpio_out_q <= gpio_sleep_q[27:0];
            end else if (!in_sleep) begin
                gpio_out_q <= i_gpio_out;
            end
            gpio_oe_q <= in_sleep ? gpio_oe_q : i_gpio_dir_out;
            gpio_in_q <= i_gpio_in;
            class8_q <= in_sleep ? class8_q : i_class8_in;
        end
    end

    // Pin class control; holds read the flags so release follows the clear by one cycle
    wire dram_hold = status_q[`SPC_ST_DH];
    wire periph_hold = status_q[`SPC_ST_PH];
    assign o_sleeping = in_sleep;
    assign o_fast_osc_stop = in_sleep & config_q[`SPC_CFG_FAST_OSC_POWERDOWN_ENABLE];
    assign o_slow_osc_ready = osc_ready_q;
    assign o_clock_config = clock_q[4:0];
    assign o_mem_class_hold_low = in_sleep | dram_hold;
    assign o_card_addr_hold_low = o_mem_class_hold_low;
    assign o_static_sleep_drive_high = in_sleep & ~config_q[`SPC_CFG_FS];
    assign o_static_ctl_oe = ~(in_sleep & config_q[`SPC_CFG_FS]);
    assign o_card_sleep_drive_high = in_sleep & ~config_q[`SPC_CFG_FP];
    assign o_card_ctl_oe = ~(in_sleep & config_q[`SPC_CFG_FP]);
    assign o_gpio_out = gpio_out_q;
    assign o_gpio_oe = gpio_oe_q;
    assign o_gpio_in_sampled = gpio_in_q;
    assign o_periph_hold = in_sleep | periph_hold;
    assign o_periph_drive_zero = o_periph_hold & pmode_q[`SPC_PM_ZERO];
    assign o_periph_float = o_periph_hold & ~pmode_q[`SPC_PM_ZERO];
    assign o_periph_rx_enable = ~in_sleep;
    assign o_class5_oe = 1'b1;
    assign o_class6_oe = ~in_sleep;
    assign o_class7_rx_enable = 1'b1;
    assign o_class8_rx_enable = ~in_sleep;
    assign o_class8_in_sampled = class8_q;

    // Checks
    default clocking spc_cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    a_bus_one_wait: assert property (req && !ack_q |=> !o_avs_waitrequest)
        else $error("waitrequest not released after one cycle");
    a_ctl_reserved_zero: assert property (
        rd_take && spc_hit(i_avs_address, `SPC_OFS_CONTROL) |=> rdata_q[31:1] == 31'h0)
        else $error("control reserved bits not zero");
    a_force_enters: assert property (!in_sleep && sf_q |=> in_sleep)
        else $error("sleep not entered on force bit");
    a_force_clears: assert property (wake_exit && !wr_ctl |=> !sf_q && !in_sleep)
        else $error("force bit survived sleep exit");
    a_gpio_sleep_load: assert property (
        sleep_entry |=> o_gpio_out == $past(gpio_sleep_q[27:0]))
        else $error("gpio sleep values not loaded");
    a_dram_hold_set: assert property (
        wake_exit |=> status_q[`SPC_ST_DH] && o_mem_class_hold_low [*2])
        else $error("memory hold not kept after exit");
    a_periph_release: assert property (
        wr_st && wbits[`SPC_ST_PH] && !in_sleep && !wake_exit |=> !o_periph_hold)
        else $error("peripheral hold not released");
    a_static_float: assert property (in_sleep && config_q[`SPC_CFG_FS] |-> !o_static_ctl_oe
        && !o_static_sleep_drive_high)
        else $error("static strobes not floated");
    a_card_drive: assert property (in_sleep && !config_q[`SPC_CFG_FP] |-> o_card_ctl_oe
        && o_card_sleep_drive_high)
        else $error("card strobes not driven high");
    a_force_ready: assert property (config_q[`SPC_CFG_FO] |=> o_slow_osc_ready)
        else $error("force ready bit ignored");
    a_fast_osc_run: assert property (!in_sleep |-> !o_fast_osc_stop)
        else $error("fast oscillator stopped while running");

    // Memory class pins: low through sleep, address-derived card pins follow them
    a_mem_low_sleep: assert property (in_sleep |-> o_mem_class_hold_low)
        else $error("memory class not held low in sleep");
    a_card_addr_follow: assert property (
        o_card_addr_hold_low == o_mem_class_hold_low)
        else $error("card address pins left the address bus");
    a_dram_release: assert property (
        wr_st && wbits[`SPC_ST_DH] && !in_sleep && !wake_exit |=> !o_mem_class_hold_low)
        else $error("memory hold not released");

    // Static and card strobes: driven high unless the float bit is set
    a_static_drive: assert property (in_sleep && !config_q[`SPC_CFG_FS] |->
        o_static_ctl_oe && o_static_sleep_drive_high)
        else $error("static strobes not driven high");
    a_card_float: assert property (in_sleep && config_q[`SPC_CFG_FP] |->
        !o_card_ctl_oe && !o_card_sleep_drive_high)
        else $error("card strobes not floated");

    // General-purpose pins: outputs and directions frozen, inputs still sampled
    a_gpio_out_held: assert property (in_sleep |=> $stable(o_gpio_out))
        else $error("gpio output moved in sleep");
    a_gpio_oe_held: assert property (in_sleep |=> $stable(o_gpio_oe))
        else $error("gpio direction moved in sleep");
    // Reset edge excluded: the sampler was cleared, not loaded, there
    a_gpio_in_sampled: assert property (
        !i_srst |=> o_gpio_in_sampled == $past(i_gpio_in))
        else $error("gpio input not sampled");

    // Peripheral class: inputs in sleep, zero or float, receivers off
    a_periph_sleep: assert property (
        in_sleep |-> o_periph_hold && !o_periph_rx_enable)
        else $error("peripheral pins not held in sleep");
    a_periph_mode: assert property (
        o_periph_hold |-> o_periph_drive_zero != o_periph_float)
        else $error("peripheral hold mode not exclusive");

    // Fifth to eighth class pins
    a_class56_sleep: assert property (in_sleep |-> o_class5_oe && !o_class6_oe)
        else $error("fifth or sixth class wrong in sleep");
    a_class78_sleep: assert property (
        in_sleep |-> o_class7_rx_enable && !o_class8_rx_enable)
        else $error("seventh or eighth class wrong in sleep");
    a_class8_ignored: assert property (
        in_sleep |=> $stable(o_class8_in_sampled))
        else $error("eighth class input observed in sleep");

    // Oscillator ready never drops once seen, short of a hard reset
    a_osc_sticky: assert property (o_slow_osc_ready |=> o_slow_osc_ready)
        else $error("oscillator ready dropped");

    c_periph_zero: cover property (in_sleep && o_periph_drive_zero);
    c_sleep_entry: cover property (sleep_entry ##1 in_sleep);
    c_wake_exit: cover property (in_sleep ##1 wake_exit ##1 o_mem_class_hold_low);
    c_hold_clear: cover property (wr_st && wbits[`SPC_ST_DH] ##1 !o_mem_class_hold_low);
    c_force_ready: cover property (wr_cfg && wbits[`SPC_CFG_FO] ##2 o_slow_osc_ready);

endmodule : spc_power_regs
`default_nettype wire

// ===== spc_pin_partner.sv
// Pin-side model: parts on the general-purpose pads and a class-8 input.
// Assumes the block's clock; pad levels are resolved here and fed back.
`timescale 1ns/1ps
`default_nettype none
module spc_pin_partner (
    // Clock
    input wire logic i_sys_clk,
    // Pad controls from the block
    input wire logic [27:0] i_gpio_out,
    input wire logic [27:0] i_gpio_oe,
    // Levels seen by the block
    output logic [27:0] o_gpio_in,
    output logic o_class8_in
);
    logic [27:0] noise_q = 28'h5A5A5A5;
    logic tgl_q = 1'b0;
    // Undriven pads wander every cycle, so a stale level never passes for a held one
    always_ff @(posedge i_sys_clk) begin
        noise_q <= ~{noise_q[26:0], noise_q[27]};
        tgl_q <= ~tgl_q; // Keeps toggling while the receiver is off
    end
    // Pad level: the block's driver wins where it is enabled
    assign o_gpio_in = (i_gpio_oe & i_gpio_out) | (~i_gpio_oe & noise_q);
    assign o_class8_in = tgl_q;
endmodule : spc_pin_partner
`default_nettype wire

// ===== sleep_pin_control_and_power_regs_test.sv
// Self-checking bench of the sleep pin control and power registers.
// Assumes spc_power_regs and spc_pin_partner are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module sleep_pin_control_and_power_regs_test;
    localparam int SETTLE = 40; // Short settle count keeps the run brief
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h00000000;
    logic [31:0] wake = 32'h00000000;
    logic [31:0] rdata;
    logic [31:0] seed = 32'h000033C3;
    logic [27:0] gdir = 28'h0000000;
    logic [27:0] gout = 28'h0000001;
    logic [27:0] gin, gpo, goe, gis;
    logic [4:0] ccfg;
    logic c8, c8s, ws, slp, fst, srdy, mhl, cahl, sdh, soe, cdh, coe;
    logic ph, pdz, pfl, prx, c5, c6, c7, c8rx;
    int fail_count = 0;
    int n_compared = 0;

    spc_power_regs #(.OSC_SETTLE_CYCLES(SETTLE)) u_dut (
        .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(ws), .i_vdd_fault(1'b0),
        .i_batt_fault(1'b0), .i_wake_sources(wake), .o_sleeping(slp), .o_fast_osc_stop(fst),
        .o_slow_osc_ready(srdy), .o_clock_config(ccfg), .o_mem_class_hold_low(mhl),
        .o_card_addr_hold_low(cahl), .o_static_sleep_drive_high(sdh), .o_static_ctl_oe(soe),
        .o_card_sleep_drive_high(cdh), .o_card_ctl_oe(coe), .i_gpio_dir_out(gdir),
        .i_gpio_out(gout), .i_gpio_in(gin), .o_gpio_out(gpo), .o_gpio_oe(goe),
        .o_gpio_in_sampled(gis), .o_periph_hold(ph), .o_periph_drive_zero(pdz),
        .o_periph_float(pfl), .o_periph_rx_enable(prx), .o_class5_oe(c5), .o_class6_oe(c6),
        .o_class7_rx_enable(c7), .o_class8_rx_enable(c8rx), .i_class8_in(c8),
        .o_class8_in_sampled(c8s));
    spc_pin_partner u_pins (.i_sys_clk(i_sys_clk), .i_gpio_out(gpo), .i_gpio_oe(goe),
        .o_gpio_in(gin), .o_class8_in(c8));

    // Clock at 100 MHz
    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    // Core-side GPIO data keeps moving so a held pad is told from a followed one
    always @(posedge i_sys_clk) begin
        gout <= {gout[26:0], ~gout[27]};
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Expected sleep strobes: static drive, static oe, card drive, card oe
    function automatic logic [3:0] strobes(input logic [3:0] cfg);
        return {~cfg[2], ~cfg[2], ~cfg[1], ~cfg[1]};
    endfunction : strobes

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t %s got %h want %h", $time, m, g, e);
        end
    endtask : chk
    // One Avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wd <= d;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (ws !== 1'b0 && n < 50);
        chk({31'h0, ws}, 32'h0, "bus answer");
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rdchk(input logic [5:0] a, input logic [31:0] e, input string m);
        bus(1'b0, a, 32'h00000000);
        chk(rdata, e, m);
    endtask : rdchk
    task automatic waitslp(input logic v);
        int k;
        k = 0;
        while (slp !== v && k < 20) begin
            @(posedge i_sys_clk);
            k++;
        end
        chk({31'h0, slp}, {31'h0, v}, "sleep state");
    endtask : waitslp
    task automatic summarize();
        $display("counts: %0d compared, %0d mismatched", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        fail_count++;
        summarize();
    end

    initial begin
        logic [31:0] x;
        logic [31:0] rv [7];
        logic [3:0] cfg;
        logic [27:0] gs, od, gi;
        logic c8h;
        rv = '{32'h0, 32'h0, 32'h0, 32'h3, 32'h0, 32'h0, 32'h0};
        repeat (6) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        rdchk(6'h1C, 32'h0, "osc not yet ready");
        chk({31'h0, srdy}, 32'h0, "ready pin low");
        foreach (rv[i]) rdchk(6'(4 * i), rv[i], "reset value");
        x = xs();
        bus(1'b1, 6'h08, x);
        rdchk(6'h08, x, "scratch");
        bus(1'b1, 6'h14, x);
        rdchk(6'h14, {27'h0, x[4:0]}, "clock config");
        chk({27'h0, ccfg}, {27'h0, x[4:0]}, "clock config pins");
        // Only the bench writes control, as protected software would
        bus(1'b1, 6'h00, 32'hFFFFFFFE);
        rdchk(6'h00, 32'h0, "control reserved");
        chk({31'h0, slp}, 32'h0, "zero force");
        bus(1'b1, 6'h24, x);
        rdchk(6'h24, 32'h0, "unmapped");
        repeat (SETTLE) @(posedge i_sys_clk);
        rdchk(6'h1C, 32'h1, "osc settled");
        for (int i = 0; i < 4; i++) begin
            cfg = {1'b0, 2'(i), 1'(i) ^ 1'(i >> 1)};
            gs = 28'(xs());
            gdir <= 28'(xs());
            bus(1'b1, 6'h10, {28'h0, cfg});
            bus(1'b1, 6'h18, {4'h0, gs});
            bus(1'b1, 6'h20, {31'h0, 1'(i)});
            rdchk(6'h10, {28'h0, cfg}, "config");
            bus(1'b1, 6'h00, 32'h00000001);
            waitslp(1'b1);
            @(posedge i_sys_clk);
            od = gdir;
            gdir <= ~gdir;
            gi = gin;
            c8h = c8s;
            @(posedge i_sys_clk);
            chk({4'h0, gpo}, {4'h0, gs}, "gpio sleep value");
            chk({4'h0, goe}, {4'h0, od}, "gpio oe held");
            chk({4'h0, gis}, {4'h0, gi}, "gpio input sampled");
            chk({29'h0, fst, mhl, cahl}, {29'h0, cfg[0], 2'b11}, "osc, low hold");
            chk({28'h0, sdh, soe, cdh, coe}, {28'h0, strobes(cfg)}, "strobes");
            chk({27'h0, c5, c6, c7, c8rx, prx}, 32'h14, "class pins");
            chk({31'h0, c8s}, {31'h0, c8h}, "class8 ignored");
            chk({29'h0, ph, pdz, pfl}, {29'h0, 1'b1, 1'(i), ~1'(i)}, "periph");
            wake <= 32'h00000001;
            waitslp(1'b0);
            wake <= 32'h00000000;
            chk({29'h0, mhl, cahl, ph}, 32'h7, "holds after wake");
            rdchk(6'h00, 32'h0, "force cleared");
            rdchk(6'h04, 32'h19, "status");
            bus(1'b1, 6'h04, 32'h00000008);
            @(posedge i_sys_clk);
            chk({29'h0, mhl, cahl, ph}, 32'h1, "row release");
            bus(1'b1, 6'h04, 32'h00000011);
            @(posedge i_sys_clk);
            chk({31'h0, ph}, 32'h0, "periph release");
            rdchk(6'h04, 32'h0, "status cleared");
        end
        // Warm reset: the oscillator is known stable, so forcing ready is allowed
        i_srst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        rdchk(6'h10, 32'h0, "config after reset");
        rdchk(6'h1C, 32'h0, "osc after reset");
        bus(1'b1, 6'h10, 32'h00000008);
        rdchk(6'h1C, 32'h1, "forced ready");
        chk({31'h0, srdy}, 32'h1, "ready pin high");
        summarize();
    end
endmodule : sleep_pin_control_and_power_regs_test
`default_nettype wire
